// File: hw/clk_ctrl_pkg.sv
// Package for the clock synthesizer control block: register map,
// configuration field positions, reset values and timing constants.
// Assumes a 25 MHz system clock that also stands in for the VCO clock.
package clk_ctrl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Silence on the reference input longer than this is a loss of signal
  localparam int unsigned LOS_TIME_NS = 10000;
  localparam int unsigned LOS_CYCLES = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam int unsigned CFG_WORDS = 8;
  localparam logic [7:0] STATUS_ADDR = 8'h20;

  // Configuration word indices
  localparam logic [2:0] W_PLL1 = 3'h0;
  localparam logic [2:0] W_PLL2 = 3'h1;
  localparam logic [2:0] W_BANK = 3'h2;
  localparam logic [2:0] W_PHASE = 3'h3;
  localparam logic [2:0] W_SREF = 3'h4;
  localparam logic [2:0] W_SMUX = 3'h5;
  localparam logic [2:0] W_MODE = 3'h6;

  // Field positions
  localparam int unsigned PRESCALE_LSB = 0;
  localparam int unsigned PLL1_FB_LSB = 8;
  localparam int unsigned VCO0_FB_LSB = 0;
  localparam int unsigned VCO1_FB_LSB = 8;
  localparam int unsigned VCO_SEL_BIT = 16;
  localparam int unsigned BANK_STRIDE = 8;
  localparam int unsigned BANK_PD_LSB = 24;
  localparam int unsigned SREF_DIV_LSB = 0;
  localparam int unsigned SREF_PER_LSB = 8;
  localparam int unsigned SREF_TRIG_BIT = 16;
  localparam int unsigned SMUX_LSB = 0;
  localparam int unsigned BYPASS_BIT = 0;
  localparam int unsigned HOLD_BIT = 1;

  // Status word bits
  localparam int unsigned ST_LOSS = 0;
  localparam int unsigned ST_LOS_LIVE = 1;
  localparam int unsigned ST_HOLDOVER = 2;
  localparam int unsigned ST_BYPASS = 3;

  // Reset values
  localparam logic [31:0] RST_PLL1 = 32'h0000_0401;
  localparam logic [31:0] RST_PLL2 = 32'h0000_0808;
  localparam logic [31:0] RST_OTHER = 32'h0000_0000;

  // Divider limits
  localparam logic [7:0] PRESCALE_MIN = 8'h01;
  localparam logic [14:0] PLL1_FB_MIN = 15'h0004;
  localparam logic [7:0] PLL2_FB_MIN = 8'h08;
  localparam int unsigned BANK_CODES = 18;
  localparam int unsigned SREF_CODES = 10;

endpackage

// File: hw/ratio_divider.sv
// Integer divider cell for one output bank or the reference pulse path.
// Assumes a ratio of at least one and a restart pulse from the same clock.
module ratio_divider #(
  parameter int unsigned W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic restart,
  input wire logic [W-1:0] ratio,
  input wire logic [W-1:0] phase,
  // Divided clock and period mark
  output logic level,
  output logic wrap
);

  logic [W-1:0] count;
  logic [W-1:0] half;

  assign half = W'((ratio + W'(1)) >> 1);

  // ==========================================================
  // Counter; a restart loads the phase offset so banks line up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (restart) begin
      count <= (phase < ratio) ? phase : '0;
    end else if (count >= ratio - W'(1)) begin
      count <= '0;
    end else begin
      count <= count + W'(1);
    end
  end

  // ==========================================================
  // Registered outputs; ratio one holds the level high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
      wrap <= 1'b0;
    end else begin
      level <= count < half;
      wrap <= !restart && (count >= ratio - W'(1));
    end
  end

endmodule

// File: hw/synth_ctrl.sv
// Control logic of a two-stage clock synthesizer: divider settings,
// bank and reference-pulse dividers, input monitor, holdover and fault pin.
// Assumes a register port on clk and an asynchronous reference input pin.
//
// Operation
// - Input prescaler is an 8-bit integer divider, ratio 1 to 255.
// - First-stage feedback divider is 15 bits, ratio 4 to 32767.
// - Each VCO has an 8-bit feedback divider 8..255; selected one applies.
// - Bank dividers use one of 18 ratios from 1 to 96.
// - Reference pulse divider uses one of 10 ratios from 64 to 2048.
// - Three clock outputs in three banks, each bank with own divider.
// - Up to four reference pulse outputs, periodic or non-periodic each.
// - Reference pulses stay synchronous to the bank clocks.
// - Each bank can be phase delayed on its own.
// - Each reference output can instead act as a bank clock output.
// - Bypass 0 runs first stage; bypass 1 feeds input to second stage.
// - Bypass disables input monitoring and jitter attenuation.
// - No input activity within a fixed time means loss of signal.
// - Loss of signal sets status bit zero.
// - Loss of signal forces holdover.
// - Hold control bit at 1 forces holdover regardless of input.
// - Configuration held as eight 32-bit words written by the host.
// - Every configuration word reads back as written, except the reference pulse trigger bit, which reads zero.
// - Active-low fault output pin signals fault conditions.
// - Holdover parks oscillator control at mid-supply; else normal.
module synth_ctrl #(
  parameter int unsigned LOS_CYCLES = clk_ctrl_pkg::LOS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Reference input pin
  input wire logic ref_clk_in,
  // Divider and mode settings to the analog loops
  output logic [7:0] pll1_prescale,
  output logic [14:0] pll1_feedback,
  output logic [7:0] pll2_feedback,
  output logic vco_select,
  output logic ref_bypass,
  output logic atten_enable,
  output logic vcxo_ctrl_mid,
  // Outputs
  output logic [2:0] bank_clock_output,
  output logic [2:0] bank_power_down,
  output logic [3:0] sysref_output,
  output logic fault_out_n
);

  // ==========================================================
  // Helpers
  function automatic logic [6:0] bank_ratio(input logic [4:0] code);
    logic [6:0] tbl [0:17];
    tbl = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h08, 7'h0a, 7'h0c,
            7'h10, 7'h14, 7'h18, 7'h20, 7'h28, 7'h30, 7'h40, 7'h50, 7'h60};
    bank_ratio = (code < 5'(clk_ctrl_pkg::BANK_CODES)) ? tbl[code] : 7'h01;
  endfunction

  function automatic logic [11:0] sref_ratio(input logic [3:0] code);
    logic [11:0] tbl [0:9];
    tbl = '{12'h040, 12'h060, 12'h080, 12'h0c0, 12'h100,
            12'h180, 12'h200, 12'h300, 12'h400, 12'h800};
    sref_ratio = (code < 4'(clk_ctrl_pkg::SREF_CODES)) ? tbl[code] : 12'h040;
  endfunction

  function automatic logic [14:0] at_least(input logic [14:0] v, input logic [14:0] lo);
    at_least = (v < lo) ? lo : v;
  endfunction

  // ==========================================================
  // Register file
  logic [31:0] cfg [0:clk_ctrl_pkg::CFG_WORDS-1];
  logic cfg_hit;
  logic [2:0] cfg_idx;
  logic status_hit;
  logic loss_status;
  logic los_live;
  logic holdover;
  logic trig_write;
  logic div_write;

  assign cfg_hit = addr[7:5] == clk_ctrl_pkg::CFG_BASE[7:5] && addr[1:0] == 2'h0;
  assign cfg_idx = addr[4:2];
  assign status_hit = addr == clk_ctrl_pkg::STATUS_ADDR;
  assign trig_write = wr && cfg_hit && cfg_idx == clk_ctrl_pkg::W_SREF &&
                      wdata[clk_ctrl_pkg::SREF_TRIG_BIT];
  // Any write to the bank, phase or reference pulse word restarts all dividers together
  assign div_write = wr && cfg_hit && (cfg_idx == clk_ctrl_pkg::W_BANK ||
                     cfg_idx == clk_ctrl_pkg::W_PHASE || cfg_idx == clk_ctrl_pkg::W_SREF);

  // Configuration words
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < clk_ctrl_pkg::CFG_WORDS; i++) begin
        cfg[i] <= clk_ctrl_pkg::RST_OTHER;
      end
      cfg[clk_ctrl_pkg::W_PLL1] <= clk_ctrl_pkg::RST_PLL1;
      cfg[clk_ctrl_pkg::W_PLL2] <= clk_ctrl_pkg::RST_PLL2;
    end else if (wr && cfg_hit) begin
      cfg[cfg_idx] <= wdata;
      // The trigger bit is an action, not a setting
      if (cfg_idx == clk_ctrl_pkg::W_SREF) begin
        cfg[cfg_idx][clk_ctrl_pkg::SREF_TRIG_BIT] <= 1'b0;
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd && cfg_hit) begin
      rdata <= cfg[cfg_idx];
    end else if (rd && status_hit) begin
      rdata <= {28'h0000000, ref_bypass, holdover, los_live, loss_status};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Configuration fields
  logic bypass_bit;
  logic hold_bit;
  logic vco_sel_bit;
  logic [7:0] pv_raw;
  logic [14:0] mv_raw;
  logic [7:0] mf_raw;
  logic [3:0] smux;
  logic [3:0] speriodic;

  assign bypass_bit = cfg[clk_ctrl_pkg::W_MODE][clk_ctrl_pkg::BYPASS_BIT];
  assign hold_bit = cfg[clk_ctrl_pkg::W_MODE][clk_ctrl_pkg::HOLD_BIT];
  assign vco_sel_bit = cfg[clk_ctrl_pkg::W_PLL2][clk_ctrl_pkg::VCO_SEL_BIT];
  assign pv_raw = cfg[clk_ctrl_pkg::W_PLL1][clk_ctrl_pkg::PRESCALE_LSB +: 8];
  assign mv_raw = cfg[clk_ctrl_pkg::W_PLL1][clk_ctrl_pkg::PLL1_FB_LSB +: 15];
  // Only the divider of the VCO in use reaches the loop
  assign mf_raw = vco_sel_bit ? cfg[clk_ctrl_pkg::W_PLL2][clk_ctrl_pkg::VCO1_FB_LSB +: 8]
                              : cfg[clk_ctrl_pkg::W_PLL2][clk_ctrl_pkg::VCO0_FB_LSB +: 8];
  assign smux = cfg[clk_ctrl_pkg::W_SMUX][clk_ctrl_pkg::SMUX_LSB +: 4];
  assign speriodic = cfg[clk_ctrl_pkg::W_SREF][clk_ctrl_pkg::SREF_PER_LSB +: 4];

  // Loop settings, clamped to the supported ranges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll1_prescale <= clk_ctrl_pkg::PRESCALE_MIN;
      pll1_feedback <= clk_ctrl_pkg::PLL1_FB_MIN;
      pll2_feedback <= clk_ctrl_pkg::PLL2_FB_MIN;
      vco_select <= 1'b0;
      bank_power_down <= 3'h0;
    end else begin
      pll1_prescale <= 8'(at_least({7'h00, pv_raw}, {7'h00, clk_ctrl_pkg::PRESCALE_MIN}));
      pll1_feedback <= at_least(mv_raw, clk_ctrl_pkg::PLL1_FB_MIN);
      pll2_feedback <= 8'(at_least({7'h00, mf_raw}, {7'h00, clk_ctrl_pkg::PLL2_FB_MIN}));
      vco_select <= vco_sel_bit;
      bank_power_down <= cfg[clk_ctrl_pkg::W_BANK][clk_ctrl_pkg::BANK_PD_LSB +: 3];
    end
  end

  // ==========================================================
  // Reference path selection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_bypass <= 1'b0;
      atten_enable <= 1'b1;
    end else begin
      ref_bypass <= bypass_bit;
      atten_enable <= !bypass_bit;
    end
  end

  // ==========================================================
  // Input activity monitor
  logic ref_meta;
  logic ref_sync;
  logic ref_last;
  logic ref_edge;
  logic [15:0] quiet;

  // Two-stage synchroniser for the asynchronous reference pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_last <= 1'b0;
    end else begin
      ref_meta <= ref_clk_in;
      ref_sync <= ref_meta;
      ref_last <= ref_sync;
    end
  end

  assign ref_edge = ref_sync != ref_last;

  // A reference too fast for clk still shows some sampled edges;
  // only true silence over the whole window counts as a loss
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 16'h0000;
      los_live <= 1'b0;
    end else if (bypass_bit) begin
      quiet <= 16'h0000;
      los_live <= 1'b0;
    end else if (ref_edge) begin
      quiet <= 16'h0000;
      los_live <= 1'b0;
    end else if (quiet >= 16'(LOS_CYCLES - 1)) begin
      los_live <= 1'b1;
    end else begin
      quiet <= quiet + 16'h0001;
    end
  end

  // Sticky loss flag; a new loss in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loss_status <= 1'b0;
    end else if (los_live) begin
      loss_status <= 1'b1;
    end else if (wr && status_hit && wdata[clk_ctrl_pkg::ST_LOSS]) begin
      loss_status <= 1'b0;
    end
  end

  // ==========================================================
  // Holdover and fault pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdover <= 1'b0;
      vcxo_ctrl_mid <= 1'b0;
      fault_out_n <= 1'b1;
    end else begin
      // Entry on either cause; exit needs both causes gone
      holdover <= los_live || hold_bit;
      vcxo_ctrl_mid <= los_live || hold_bit;
      fault_out_n <= !(los_live || loss_status);
    end
  end

  // ==========================================================
  // Bank dividers
  logic [2:0] bank_level;
  logic [2:0] bank_restart;

  genvar b;
  generate
    for (b = 0; b < 3; b++) begin : g_bank
      logic [4:0] code;
      logic [5:0] phase;
      assign code = cfg[clk_ctrl_pkg::W_BANK][b*clk_ctrl_pkg::BANK_STRIDE +: 5];
      assign phase = cfg[clk_ctrl_pkg::W_PHASE][b*clk_ctrl_pkg::BANK_STRIDE +: 6];
      // A powered-down bank is held in restart
      assign bank_restart[b] = div_write || bank_power_down[b];
      ratio_divider #(
        .W(7)
      ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .restart(bank_restart[b]),
        .ratio(bank_ratio(code)),
        .phase({1'b0, phase}),
        .level(bank_level[b]),
        .wrap()
      );
    end
  endgenerate

  assign bank_clock_output = bank_level;

  // ==========================================================
  // Reference pulse divider
  logic sref_level;
  logic sref_wrap;
  logic [3:0] sref_code;

  assign sref_code = cfg[clk_ctrl_pkg::W_SREF][clk_ctrl_pkg::SREF_DIV_LSB +: 4];

  ratio_divider #(
    .W(12)
  ) u_sref (
    .clk(clk),
    .arst_n(arst_n),
    .restart(div_write),
    .ratio(sref_ratio(sref_code)),
    .phase(12'h000),
    .level(sref_level),
    .wrap(sref_wrap)
  );

  // One-shot mode: a trigger arms one full pulse period
  logic burst_arm;
  logic burst;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_arm <= 1'b0;
      burst <= 1'b0;
    end else begin
      if (trig_write) begin
        burst_arm <= 1'b1;
      end else if (sref_wrap) begin
        burst_arm <= 1'b0;
      end
      if (sref_wrap) begin
        burst <= burst_arm;
      end
    end
  end

  // Each output picks its bank clock or the pulse stream
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sysref_output <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!smux[i]) begin
          sysref_output[i] <= bank_level[i/2];
        end else if (speriodic[i]) begin
          sysref_output[i] <= sref_level;
        end else begin
          sysref_output[i] <= sref_level && burst;
        end
      end
    end
  end

endmodule

// File: verif/ref_source.sv
// Reference clock source that feeds the input monitor of synth_ctrl.
// Assumes the bench starts and stops it; its phase never meets clk edges.
module ref_source #(
  parameter int unsigned HALF_NS = 46
) (
  // Control
  input wire logic run,
  // Reference pin
  output logic ref_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Odd offset keeps toggles off the 40 ns grid of the system clock
  initial begin
    ref_clk = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      if (run) begin
        ref_clk = ~ref_clk;
      end
    end
  end
endmodule

// File: verif/synth_ctrl_monitor.sv
// Checker for synth_ctrl: register port, divider limits, loss and holdover.
// Assumes it is bound to synth_ctrl and sees only that module's ports.
module synth_ctrl_monitor #(
  parameter int unsigned LOS_CYCLES = 250
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Reference pin and loop settings
  input wire logic ref_clk_in,
  input wire logic [7:0] pll1_prescale,
  input wire logic [14:0] pll1_feedback,
  input wire logic [7:0] pll2_feedback,
  input wire logic ref_bypass,
  input wire logic atten_enable,
  input wire logic vcxo_ctrl_mid,
  input wire logic fault_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Quiet time of the reference pin, as seen on clk
  logic ref_last;
  int unsigned quiet;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_last <= 1'b0;
      quiet <= 0;
    end else begin
      ref_last <= ref_clk_in;
      if (ref_bypass || ref_clk_in != ref_last) begin
        quiet <= 0;
      end else if (quiet < LOS_CYCLES + 8) begin
        quiet <= quiet + 1;
      end
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_mode_write;
    wr && addr == 8'h18;
  endsequence
  sequence s_hold_write;
    s_mode_write ##0 wdata[1];
  endsequence
  // Margin of six covers the two-flop synchroniser and the fault register
  sequence s_quiet_long;
    quiet == LOS_CYCLES + 6;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property (rd && addr == 8'h24 |=> rdata == 32'h0)
    else $error("unmapped address read not zero");
  AST_PRESCALE: assert property (pll1_prescale != 8'h00)
    else $error("prescaler ratio below one");
  AST_FEEDBACK: assert property (pll1_feedback >= 15'h0004)
    else $error("first stage feedback below four");
  AST_PLL2_FB: assert property (pll2_feedback >= 8'h08)
    else $error("second stage feedback below eight");
  AST_ATTEN: assert property (atten_enable != ref_bypass)
    else $error("attenuation not inverse of bypass");
  AST_BYPASS: assert property (s_mode_write |-> ##2 ref_bypass == $past(wdata[0], 2))
    else $error("bypass output does not follow written bit");
  AST_HOLD: assert property (s_hold_write |-> ##2 vcxo_ctrl_mid)
    else $error("hold bit did not park control voltage");
  AST_LOS_FALL: assert property ($fell(fault_out_n) |-> quiet >= LOS_CYCLES && !ref_bypass)
    else $error("fault raised without a long quiet input");
  AST_LOS_HOLD: assert property (s_quiet_long |-> !fault_out_n && vcxo_ctrl_mid)
    else $error("long quiet input without fault and holdover");
endmodule

bind synth_ctrl synth_ctrl_monitor #(.LOS_CYCLES(LOS_CYCLES)) u_mon (
  .clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ref_clk_in, .pll1_prescale,
  .pll1_feedback, .pll2_feedback, .ref_bypass, .atten_enable, .vcxo_ctrl_mid,
  .fault_out_n
);

// File: verif/synth_ctrl_tb.sv
// Self-checking bench for synth_ctrl with a stoppable reference source.
// Assumes the loss timeout is shortened through LOS_CYCLES.
module synth_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned LOSC = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b1;
  logic [31:0] rdata;
  logic ref_clk_in;
  logic [7:0] pre;
  logic [14:0] fb;
  logic [7:0] fb2;
  logic vsel, byp, att, mid, fault_n;
  logic [2:0] bank, pdn;
  logic [3:0] sref;
  logic [6:0] obs;
  int n_errors = 0;
  int samples_checked = 0;
  int bank_r[18] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 16, 20, 24, 32, 40, 48, 64, 80, 96};
  int sref_r[10] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024, 2048};

  assign obs = {sref, bank};
  always #20 clk = ~clk;

  ref_source u_ref (.run(run), .ref_clk(ref_clk_in));
  synth_ctrl #(.LOS_CYCLES(LOSC)) u_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ref_clk_in(ref_clk_in), .pll1_prescale(pre), .pll1_feedback(fb),
    .pll2_feedback(fb2), .vco_select(vsel), .ref_bypass(byp), .atten_enable(att),
    .vcxo_ctrl_mid(mid), .bank_clock_output(bank), .bank_power_down(pdn),
    .sysref_output(sref), .fault_out_n(fault_n)
  );

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", exp, rdata);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_fault(input logic exp);
    int i;
    for (i = 0; i < 200; i++) begin
      settle();
      if (fault_n === exp) break;
    end
    if (i == 200) begin
      check("fault_out_n", {31'h0, exp}, {31'h0, fault_n});
      print_verdict();
    end
  endtask

  // Cycles between two rising edges of one output, zero if fewer than three rises;
  // the first rise after a restart may come early, so it is skipped
  task automatic period(input int idx, input int exp);
    logic p;
    int n, t, r;
    t = 0;
    r = 0;
    #1;
    p = obs[idx];
    for (n = 0; n < 7000 && r < 3; n++) begin
      settle();
      if (obs[idx] && !p) begin
        r++;
        t = (r == 3) ? n - t : n;
      end
      p = obs[idx];
    end
    check("period", exp, (r == 3) ? 32'(t) : 32'h0);
    if (r < 3) begin
      print_verdict();
    end
  endtask

  // Rising edges of one output over a number of cycles
  task automatic count_rises(input int idx, input int cycles, output int r);
    logic p;
    r = 0;
    #1;
    p = obs[idx];
    repeat (cycles) begin
      settle();
      if (obs[idx] && !p) begin
        r++;
      end
      p = obs[idx];
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    settle();
    check("prescale", 32'h1, {24'h0, pre});
    check("feedback", 32'h4, {17'h0, fb});
    check("fault", 32'h1, {31'h0, fault_n});
    rd_reg(8'h00, clk_ctrl_pkg::RST_PLL1);
    rd_reg(8'h04, clk_ctrl_pkg::RST_PLL2);
    rd_reg(8'h1c, clk_ctrl_pkg::RST_OTHER);
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int w = 0; w < 8; w++) wr_reg(8'(w * 4), {8'h5a, 8'(w), 16'h0c3c});
    for (int w = 0; w < 8; w++) rd_reg(8'(w * 4), {8'h5a, 8'(w), 16'h0c3c});
    check("power down", 32'h2, {29'h0, pdn});
    wr_reg(8'h24, 32'hffff_ffff);
    rd_reg(8'h24, 32'h0);
    wr_reg(8'h00, 32'h0);
    settle();
    check("prescale", 32'h1, {24'h0, pre});
    check("feedback", 32'h4, {17'h0, fb});
    wr_reg(8'h00, 32'h007f_ffff);
    settle();
    check("prescale", 32'hff, {24'h0, pre});
    check("feedback", 32'h7fff, {17'h0, fb});
    wr_reg(8'h04, 32'h0001_2010);
    settle();
    check("pll2", 32'h20, {24'h0, fb2});
    check("vco select", 32'h1, {31'h0, vsel});
    wr_reg(8'h04, 32'h0000_2003);
    settle();
    check("pll2", 32'h8, {24'h0, fb2});
    check("vco select", 32'h0, {31'h0, vsel});
    $display("test registers done");
  endtask

  task automatic t_banks();
    wr_reg(8'h14, 32'h0000_000f);
    wr_reg(8'h10, 32'h0000_0f00);
    for (int c = 1; c < 18; c++) begin
      wr_reg(8'h08, {11'h0, 5'd6, 3'h0, 5'(c), 8'h00});
      period(1, bank_r[c]);
      period(2, 8);
    end
    settle();
    check("ratio one", 32'h1, {31'h0, obs[0]});
    for (int c = 0; c < 10; c++) begin
      wr_reg(8'h10, {20'h0, 4'hf, 4'h0, 4'(c)});
      period(3 + c % 4, sref_r[c]);
    end
    wr_reg(8'h08, 32'h0000_0001);
    wr_reg(8'h14, 32'h0000_000e);
    period(3, 2);
    $display("test dividers done");
  endtask

  // A non-periodic output stays low until triggered, then gives one pulse
  task automatic t_oneshot();
    int r;
    wr_reg(8'h14, 32'h0000_000f);
    wr_reg(8'h10, 32'h0000_0e00);
    count_rises(3, 200, r);
    check("idle pulses", 32'h0, 32'(r));
    wr_reg(8'h10, 32'h0001_0e00);
    count_rises(3, 300, r);
    check("one-shot pulses", 32'h1, 32'(r));
    $display("test one-shot done");
  endtask

  task automatic t_hold();
    wr_reg(8'h18, 32'h2);
    settle();
    check("mid", 32'h1, {31'h0, mid});
    rd_reg(8'h20, 32'h4);
    wr_reg(8'h18, 32'h0);
    settle();
    check("mid", 32'h0, {31'h0, mid});
    $display("test hold done");
  endtask

  task automatic t_bypass();
    wr_reg(8'h18, 32'h1);
    settle();
    check("bypass", 32'h1, {31'h0, byp});
    check("atten", 32'h0, {31'h0, att});
    run = 1'b0;
    repeat (LOSC + 20) @(posedge clk);
    check("fault", 32'h1, {31'h0, fault_n});
    rd_reg(8'h20, 32'h8);
    run = 1'b1;
    wr_reg(8'h18, 32'h0);
    settle();
    check("atten", 32'h1, {31'h0, att});
    $display("test bypass done");
  endtask

  task automatic t_loss();
    run = 1'b0;
    wait_fault(1'b0);
    rd_reg(8'h20, 32'h7);
    check("mid", 32'h1, {31'h0, mid});
    run = 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(8'h20, 32'h1);
    check("mid", 32'h0, {31'h0, mid});
    check("fault", 32'h0, {31'h0, fault_n});
    wr_reg(8'h20, 32'h1);
    wait_fault(1'b1);
    rd_reg(8'h20, 32'h0);
    $display("test loss done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_banks();
    t_oneshot();
    t_hold();
    t_bypass();
    t_loss();
    print_verdict();
  end
endmodule
